// ### rtl/jlt_consts.svh
`ifndef JLT_CONSTS_SVH
`define JLT_CONSTS_SVH
// control characters, given as the octet sent with the k flag set
`define JLT_K28_0 8'h1C
`define JLT_K28_3 8'h7C
`define JLT_K28_4 8'h9C
`define JLT_K28_5 8'hBC
`define JLT_K28_7 8'hFC
// fixed link parameters (values, not minus-one forms)
`define JLT_N 5'h0E
`define JLT_NP 5'h10
`define JLT_S 5'h01
`define JLT_CF 5'h00
`define JLT_HD 1'h0
`define JLT_JESDV 3'h1
// index of the last ilas multiframe: four of them
`define JLT_ILAS_LAST 2'h3
// first position after the config octets in the second multiframe
`define JLT_CFG_END 7'h10
// consecutive comma symbols before a lane counts as locked
`define JLT_CGS_LOCK 3'h4
`define JLT_PRBS_SEED 15'h7FFF
// receiver register map, byte addresses
`define JLT_REG_CTRL 4'h0
`define JLT_REG_STAT 4'h4
`define JLT_REG_DATA0 4'h8
`define JLT_REG_DATA1 4'hC
// ctrl reset: enabled, subclass 0, scrambling on, two lanes, k-1 = 31
`define JLT_CTRL_RST 9'h1FD
`endif

// ### rtl/jlt_pkg.sv
package jlt_pkg;
   // transmitter phases, gray along cgs -> wait -> ilas -> data
   typedef enum logic [1:0] {TX_CGS = 2'h0, TX_WAIT = 2'h1, TX_ILAS = 2'h3,
                             TX_DATA = 2'h2} jlt_txst_t;
   // receiver phases, gray along sync -> sysref -> wait -> link
   typedef enum logic [1:0] {RX_SYNC = 2'h0, RX_SREF = 2'h1, RX_WAIT = 2'h3,
                             RX_LINK = 2'h2} jlt_rxst_t;
   // tail bit sources
   typedef enum logic [1:0] {TAIL_ZERO = 2'h0, TAIL_PRBS = 2'h1,
                             TAIL_CTRL = 2'h2} jlt_tail_t;
   // static transmitter configuration
   typedef struct packed {
      logic       two_conv;  // converters: 1 = two
      logic       two_lane;  // lanes: 1 = two
      logic       swap;      // exchange a and b paths
      logic       scr_en;    // scrambling
      logic       subclass1; // 0 = subclass 0
      logic [1:0] cs_num;    // control bits per sample, 0..2
      jlt_tail_t  tail_sel;  // tail bit source
      logic [4:0] k_m1;      // frames per multiframe minus one
      logic [7:0] did;
      logic [3:0] bid;
      logic [4:0] lid0;
      logic [4:0] lid1;
   } jlt_cfg_t;
   // receiver control register
   typedef struct packed {
      logic [4:0] k_m1;
      logic       two_lane;
      logic       scr;
      logic       sub1;
      logic       en;
   } jlt_rxctl_t;
   // transmitter state
   typedef struct packed {
      jlt_txst_t        st;
      logic [1:0]       oct;     // octet in frame
      logic [4:0]       frm;     // frame in multiframe, the lmfc
      logic [1:0]       mf;      // ilas multiframe
      logic             sref_d;
      logic             realign;
      logic [13:0]      hx;
      logic [13:0]      hy;
      logic [1:0]       tx;
      logic [1:0]       ty;
      logic [14:0]      prbs;
      logic [1:0][14:0] scr;
      logic [1:0][7:0]  prev;
      logic [1:0]       rd;
      logic [1:0][9:0]  sym;
      logic [1:0][7:0]  fchk;
   } jlt_tx_t;
   // receiver state
   typedef struct packed {
      jlt_rxst_t        st;
      jlt_rxctl_t       ctl;
      logic [1:0][2:0]  cnt;     // comma run per lane
      logic [1:0]       oct;
      logic [4:0]       frm;
      logic [1:0]       acnt;    // ilas /A/ seen on lane 0
      logic             dat;
      logic             sync;
      logic             sysref;
      logic [1:0][14:0] dsc;
      logic [1:0][7:0]  last;
      logic [1:0][31:0] shr;
      logic             ack;
      logic [31:0]      rdata;
   } jlt_rx_t;

   // 5b/6b and 3b/4b codes for negative running disparity
   localparam logic [5:0] CODE6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] CODE4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   // 8b/10b: returns {new disparity, abcdei, fghj}; rd high = positive
   function automatic logic [10:0] jlt_enc(input logic [7:0] d, input logic k,
                                            input logic rd);
      logic [5:0] c6;
      logic [3:0] c4;
      logic       r;
      logic       alt;
      c6 = k ? 6'h0F : CODE6[d[4:0]];
      r = rd;
      if (r && ($countones(c6) != 3 || c6 == 6'h38)) begin
         c6 = ~c6;
      end
      if ($countones(c6) != 3) begin
         r = ~r;
      end
      // alternate x.7 avoids a run of five equal bits
      alt = (d[7:5] == 3'h7) && (k ||
            (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
            (r && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
      c4 = alt ? 4'h7 : CODE4[d[7:5]];
      if (r && ($countones(c4) != 2 || c4 == 4'hC)) begin
         c4 = ~c4;
      end else if (k && !r && $countones(c4) == 2 && c4 != 4'hC) begin
         // balanced tails of a control code follow the 6b disparity
         c4 = ~c4;
      end
      if ($countones(c4) != 2) begin
         r = ~r;
      end
      return {r, c6, c4};
   endfunction

   // self-synchronising 1 + x^14 + x^15, msb first; inv selects the descrambler
   function automatic logic [22:0] jlt_scr(input logic [7:0] d, input logic [14:0] s,
                                            input logic inv);
      logic [14:0] st;
      logic [7:0]  o;
      st = s;
      o = '0;
      for (int i = 7; i >= 0; i--) begin
         o[i] = d[i] ^ st[13] ^ st[14];
         st = {st[13:0], inv ? d[i] : o[i]};
      end
      return {st, o};
   endfunction
endpackage

// ### rtl/jlt_link_if.sv
interface jlt_link_if;
   logic [9:0] serial_lane0_output;     // lane 0 symbol, first bit sent in [9]
   logic [9:0] serial_lane1_output;     // lane 1 symbol
   logic       sync_request_input_pair; // sync level, low requests resync
   logic       sysref;                  // alignment strobe from the receiver
   modport tx (output serial_lane0_output, output serial_lane1_output,
               input sync_request_input_pair, input sysref);
   modport rx (input serial_lane0_output, input serial_lane1_output,
               output sync_request_input_pair, output sysref);
endinterface

// ### rtl/jlt_tx.sv
// Functional notes
// - fixed S=1, N=14, N'=16, CF=0, HD=0
// - one or two converters and lanes, F=4/2
// - control bits 0..2, frames per multiframe set
// - default A on lane 0, B lane 1
// - sample split msb octet, then lsb plus tails
// - tails zero, pseudo-random or control bits
// - optional scrambler 1 + x^14 + x^15
// - receiver descrambles with self-synchronising inverse
// - every octet 8b/10b encoded per lane
// - unscrambled repeat at multiframe end gives K28.3
// - unscrambled repeat at frame end gives K28.7
// - scrambled 0x7C at multiframe end gives K28.3
// - scrambled 0xFC at frame end gives K28.7
// - only data phase octets are scrambled
// - cgs sends K28.5 on active lanes
// - receiver locks onto K28.5 per lane
// - sysref edge sets the local multiframe clock
// - sysref edge realigns converter sampling
// - sync release starts ilas, lmfc-aligned in subclass1
// - subclass 0 and 1 share the phase sequence
// - link checksum kept readable
// - ilas four multiframes, K28.0 first, K28.3 last
// - second multiframe K28.4 then fourteen config octets
module jlt_tx
   import jlt_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire jlt_pkg::jlt_cfg_t  cfg,
   input  wire logic [13:0]        samp_a,
   input  wire logic [13:0]        samp_b,
   input  wire logic               ovr_range,
   input  wire logic               und_range,
   input  wire logic               samp_valid,
   output logic                    samp_take,
   output logic                    samp_realign,
   output logic [7:0]              fchk0,
   output logic [7:0]              fchk1,
   output logic                    link_up,
   jlt_link_if.tx                  link
);
   `include "jlt_consts.svh"

   jlt_tx_t    q;       // registered state
   jlt_tx_t    n;       // next state
   logic [1:0] fm1;     // octets per frame minus one
   logic       lastoct; // last octet of a frame
   logic       mfend;   // last octet of a multiframe

   ////////////////////////////////////////////////////////////////////////////
   // link parameter helpers

   // checksum is the byte sum of the parameter fields, not of the octets
   function automatic logic [7:0] lane_fchk(input jlt_cfg_t c, input logic [4:0] lid,
                                            input logic [1:0] f);
      return c.did + 8'(c.bid) + 8'(lid) + 8'(c.scr_en) + 8'(c.two_lane) + 8'(f)
             + 8'(c.k_m1) + 8'(c.two_conv) + 8'(`JLT_N - 5'h01) + 8'(c.cs_num)
             + 8'(`JLT_NP - 5'h01) + 8'(c.subclass1) + 8'(`JLT_S - 5'h01)
             + 8'(`JLT_JESDV) + 8'(`JLT_HD) + 8'(`JLT_CF);
   endfunction

   // config octet i of the second ilas multiframe
   function automatic logic [7:0] ilas_cfg(input jlt_cfg_t c, input logic [4:0] lid,
                                           input logic [1:0] f, input logic [3:0] i);
      logic [7:0] o;
      o = 8'h00;
      unique case (i)
         4'h0: o = c.did;
         4'h1: o = {4'h0, c.bid};
         4'h2: o = {3'h0, lid};
         4'h3: o = {c.scr_en, 6'h00, c.two_lane};
         4'h4: o = {6'h00, f};
         4'h5: o = {3'h0, c.k_m1};
         4'h6: o = {7'h00, c.two_conv};
         4'h7: o = {c.cs_num, 1'b0, `JLT_N - 5'h01};
         4'h8: o = {2'h0, c.subclass1, `JLT_NP - 5'h01};
         4'h9: o = {`JLT_JESDV, `JLT_S - 5'h01};
         4'hA: o = {`JLT_HD, 2'h0, `JLT_CF};
         4'hD: o = lane_fchk(c, lid, f);
         default: o = 8'h00; // reserved octets 11 and 12
      endcase
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // frame timing shared by all processes

   assign fm1 = cfg.two_lane ? 2'h1 : 2'h3;
   assign lastoct = (q.oct == fm1);
   assign mfend = lastoct && (q.frm == cfg.k_m1);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic        srise;
      logic        hi;
      logic [6:0]  pos;
      logic [13:0] sx;
      logic [13:0] sy;
      logic [13:0] smp;
      logic [1:0]  ctl;
      logic [1:0]  tl;
      logic [7:0]  oc;
      logic        kc;
      logic [10:0] e;
      logic [22:0] sc;
      srise = 1'b0;
      hi = 1'b0;
      pos = '0;
      sx = '0;
      sy = '0;
      smp = '0;
      ctl = '0;
      tl = '0;
      oc = '0;
      kc = 1'b0;
      e = '0;
      sc = '0;
      n = q;

      // sysref acts on its rising edge, subclass 1 only
      srise = link.sysref && !q.sref_d && cfg.subclass1;
      n.sref_d = link.sysref;
      n.realign = srise;
      pos = cfg.two_lane ? {1'b0, q.frm, q.oct[0]} : {q.frm, q.oct};

      // frame and multiframe counters free-run; sysref zeroes them
      n.oct = lastoct ? 2'h0 : q.oct + 2'h1;
      if (lastoct) begin
         n.frm = mfend ? 5'h00 : q.frm + 5'h01;
      end
      if (srise) begin
         n.oct = 2'h0;
         n.frm = 5'h00;
      end

      // phase sequence, common to both subclasses
      unique case (q.st)
         TX_CGS: begin
            if (link.sync_request_input_pair) begin
               n.st = TX_WAIT;
            end
         end
         TX_WAIT: begin
            if (!cfg.subclass1) begin
               n.st = TX_ILAS;
               n.oct = 2'h0;
               n.frm = 5'h00;
               n.mf = 2'h0;
            end else if (mfend) begin
               n.st = TX_ILAS;
               n.mf = 2'h0;
            end
         end
         TX_ILAS: begin
            if (mfend) begin
               n.mf = q.mf + 2'h1;
               if (q.mf == `JLT_ILAS_LAST) begin
                  n.st = TX_DATA;
               end
            end
         end
         TX_DATA: begin
            n.st = TX_DATA;
            n.mf = lastoct ? 2'h1 : q.mf; // mf 0 marks the first data frame
         end
      endcase
      // a held-low sync overrides everything, at any phase
      if (!link.sync_request_input_pair) begin
         n.st = TX_CGS;
      end

      // control bits, narrowed to the configured count
      if (cfg.cs_num == 2'h2) begin
         ctl = {ovr_range || und_range, samp_valid};
      end else if (cfg.cs_num == 2'h1) begin
         ctl = {ovr_range || und_range, 1'b0};
      end

      // samples are held one frame so the whole frame reads from flops
      sx = cfg.swap ? samp_b : samp_a;
      sy = cfg.swap ? samp_a : samp_b;
      if (lastoct) begin
         n.hx = sx;
         n.hy = cfg.two_conv ? sy : 14'h0000;
         n.tx = (cfg.tail_sel == TAIL_PRBS) ? q.prbs[1:0] :
                (cfg.tail_sel == TAIL_CTRL) ? ctl : 2'h0;
         n.ty = (cfg.tail_sel == TAIL_PRBS) ? q.prbs[3:2] :
                (cfg.tail_sel == TAIL_CTRL) ? ctl : 2'h0;
         n.prbs = {q.prbs[13:0], q.prbs[14] ^ q.prbs[13]};
      end

      // per lane octet choice, scrambling, replacement and encoding
      for (int l = 0; l < 2; l++) begin
         hi = cfg.two_lane ? l[0] : q.oct[1];
         smp = hi ? q.hy : q.hx;
         tl = hi ? q.ty : q.tx;
         oc = q.oct[0] ? {smp[5:0], tl} : smp[13:6];
         kc = 1'b0;
         unique case (q.st)
            TX_CGS, TX_WAIT: begin
               oc = `JLT_K28_5;
               kc = 1'b1;
            end
            TX_ILAS: begin
               kc = 1'b1;
               if (pos == 7'h00) begin
                  oc = `JLT_K28_0;
               end else if (mfend) begin
                  oc = `JLT_K28_3;
               end else if (q.mf == 2'h1 && pos == 7'h01) begin
                  oc = `JLT_K28_4;
               end else if (q.mf == 2'h1 && pos < `JLT_CFG_END) begin
                  kc = 1'b0;
                  oc = ilas_cfg(cfg, l[0] ? cfg.lid1 : cfg.lid0, fm1,
                                4'(pos - 7'h02));
               end else begin
                  kc = 1'b0;
                  oc = {1'b0, pos};
               end
            end
            TX_DATA: begin
               if (cfg.scr_en) begin
                  sc = jlt_scr(oc, q.scr[l], 1'b0);
                  oc = sc[7:0];
                  n.scr[l] = sc[22:8];
               end
               if (lastoct) begin
                  n.prev[l] = oc;
                  if (cfg.scr_en) begin
                     if (mfend && oc == `JLT_K28_3) begin
                        kc = 1'b1;
                     end else if (!mfend && oc == `JLT_K28_7) begin
                        kc = 1'b1;
                     end
                  end else if (oc == q.prev[l] && q.mf != 2'h0) begin
                     kc = 1'b1;
                     oc = mfend ? `JLT_K28_3 : `JLT_K28_7;
                  end
               end
            end
         endcase
         e = jlt_enc(oc, kc, q.rd[l]);
         n.sym[l] = e[9:0];
         n.rd[l] = e[10];
      end
      // an unused second lane stays quiet
      if (!cfg.two_lane) begin
         n.sym[1] = 10'h000;
         n.rd[1] = 1'b0;
      end
      n.fchk[0] = lane_fchk(cfg, cfg.lid0, fm1);
      n.fchk[1] = lane_fchk(cfg, cfg.lid1, fm1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; the prbs must never start from all zeros

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.prbs <= `JLT_PRBS_SEED;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign samp_take = lastoct;
   assign samp_realign = q.realign;
   assign fchk0 = q.fchk[0];
   assign fchk1 = q.fchk[1];
   assign link_up = (q.st == TX_DATA);
   assign link.serial_lane0_output = q.sym[0];
   assign link.serial_lane1_output = q.sym[1];
endmodule

// ### rtl/jlt_rx.sv
module jlt_rx
   import jlt_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   jlt_link_if.rx           link
);
   `include "jlt_consts.svh"

   localparam logic [7:0] KSET [5] = '{`JLT_K28_0, `JLT_K28_3, `JLT_K28_4,
                                      `JLT_K28_5, `JLT_K28_7};

   jlt_rx_t q; // registered state
   jlt_rx_t n; // next state

   // brute-force decode against both disparities: {valid, k, octet}
   // costly in area, but it cannot disagree with the encoder
   function automatic logic [9:0] sym_dec(input logic [9:0] c);
      logic [9:0]  r;
      logic [10:0] e;
      r = '0;
      e = '0;
      for (int i = 0; i < 512; i++) begin
         e = jlt_enc(8'(i), 1'b0, i[8]);
         if (e[9:0] == c) begin
            r = {2'b10, 8'(i)};
         end
      end
      for (int j = 0; j < 10; j++) begin
         e = jlt_enc(KSET[j / 2], 1'b1, j[0]);
         if (e[9:0] == c) begin
            r = {2'b11, KSET[j / 2]};
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [1:0]  fm1;
      logic        lastoct;
      logic        mfend;
      logic        locked;
      logic        lost;
      logic        act;
      logic [9:0]  dv;
      logic [7:0]  od;
      logic [22:0] sc;
      n = q;
      fm1 = q.ctl.two_lane ? 2'h1 : 2'h3;
      lastoct = (q.oct == fm1);
      mfend = lastoct && (q.frm == q.ctl.k_m1);
      locked = 1'b1;
      lost = 1'b0;
      act = 1'b0;
      dv = '0;
      od = '0;
      sc = '0;

      // local frame and multiframe counters
      n.oct = lastoct ? 2'h0 : q.oct + 2'h1;
      if (lastoct) begin
         n.frm = mfend ? 5'h00 : q.frm + 5'h01;
      end
      n.sysref = 1'b0;

      // per lane lock, ilas tracking and data recovery
      for (int l = 0; l < 2; l++) begin
         act = (l == 0) || q.ctl.two_lane;
         dv = sym_dec(l[0] ? link.serial_lane1_output : link.serial_lane0_output);
         if (dv[9:8] == 2'b11 && dv[7:0] == `JLT_K28_5) begin
            if (q.cnt[l] != `JLT_CGS_LOCK) begin
               n.cnt[l] = q.cnt[l] + 3'h1;
            end
         end else if (q.st != RX_LINK) begin
            n.cnt[l] = 3'h0;
         end
         if (act && q.cnt[l] != `JLT_CGS_LOCK) begin
            locked = 1'b0;
         end
         if (act && q.st == RX_LINK && !dv[9]) begin
            lost = 1'b1;
         end
         if (q.dat && act) begin
            // a replaced octet stands for the previous frame's last one
            od = (dv[8] && !q.ctl.scr) ? q.last[l] : dv[7:0];
            sc = jlt_scr(od, q.dsc[l], 1'b1);
            if (q.ctl.scr) begin
               n.dsc[l] = sc[22:8];
            end
            if (lastoct) begin
               n.last[l] = od;
            end
            n.shr[l] = {q.shr[l][23:0], q.ctl.scr ? sc[7:0] : od};
         end
         // count /A/ on lane 0 through the four ilas multiframes
         if (l == 0 && q.st == RX_LINK && !q.dat && dv[9:8] == 2'b11 &&
             dv[7:0] == `JLT_K28_3) begin
            n.acnt = q.acnt + 2'h1;
            if (q.acnt == `JLT_ILAS_LAST) begin
               n.dat = 1'b1;
               n.oct = 2'h0;
               n.frm = 5'h00;
            end
         end
      end

      // sync and sysref sequencing
      unique case (q.st)
         RX_SYNC: begin
            if (locked && q.ctl.en) begin
               if (q.ctl.sub1) begin
                  n.st = RX_SREF;
               end else begin
                  n.st = RX_LINK;
                  n.sync = 1'b1;
               end
            end
         end
         RX_SREF: begin
            n.sysref = 1'b1;
            n.oct = 2'h0;
            n.frm = 5'h00;
            n.st = RX_WAIT;
         end
         RX_WAIT: begin
            if (mfend) begin
               n.st = RX_LINK;
               n.sync = 1'b1;
            end
         end
         RX_LINK: begin
            n.st = RX_LINK;
         end
      endcase
      // disable or a bad symbol sends the link back to cgs
      if (!q.ctl.en || lost) begin
         n.st = RX_SYNC;
         n.sync = 1'b0;
         n.dat = 1'b0;
         n.acnt = 2'h0;
         n.cnt = '0;
      end

      // avalon slave: one wait cycle, then the answer
      n.ack = (avs_read || avs_write) && !q.ack;
      if (avs_read && !q.ack) begin
         case (avs_address)
            `JLT_REG_CTRL: n.rdata = {23'h000000, q.ctl};
            `JLT_REG_STAT: n.rdata = {26'h0000000, q.dat, q.sync,
                                      q.cnt[1] == `JLT_CGS_LOCK,
                                      q.cnt[0] == `JLT_CGS_LOCK, q.st};
            `JLT_REG_DATA0: n.rdata = q.shr[0];
            `JLT_REG_DATA1: n.rdata = q.shr[1];
            default: n.rdata = 32'h00000000;
         endcase
      end
      if (avs_write && q.ack && avs_address == `JLT_REG_CTRL) begin
         if (avs_byteenable[0]) begin
            n.ctl[7:0] = avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            n.ctl[8] = avs_writedata[8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         q <= '0;
         q.ctl <= `JLT_CTRL_RST;
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign avs_waitrequest = (avs_read || avs_write) && !q.ack;
   assign avs_readdata = q.rdata;
   assign link.sync_request_input_pair = q.sync;
   assign link.sysref = q.sysref;
endmodule

// ### verif/jlt_link_sva.sv
module jlt_link_sva (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic [9:0] serial_lane0_output,
   input wire logic [9:0] serial_lane1_output,
   input wire logic       sync_request_input_pair,
   input wire logic       sysref
);
   // lane 0 control symbols, either running disparity
   wire k5 = serial_lane0_output inside {10'h0FA, 10'h305};
   wire k0 = serial_lane0_output inside {10'h0F4, 10'h30B};
   wire k3 = serial_lane0_output inside {10'h0F3, 10'h30C};
   wire sy = sync_request_input_pair;
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_cgs_comma; !sy |-> ##2 k5; endproperty
   a_cgs_comma: assert property (p_cgs_comma) else $error("no comma in cgs");
   // each comma flips disparity, so a frozen symbol register shows up here
   property p_cgs_alt; !sy ##1 !sy |-> ##2 serial_lane0_output != $past(serial_lane0_output); endproperty
   a_cgs_alt: assert property (p_cgs_alt) else $error("disparity stuck");
   property p_sref_pulse; sysref |=> !sysref; endproperty
   a_sref_pulse: assert property (p_sref_pulse) else $error("sysref too long");
   property p_sref_in_sync; sysref |-> !sy; endproperty
   a_sref_in_sync: assert property (p_sref_in_sync) else $error("late sysref");
   property p_lock; $rose(sy) |-> $past(k5, 1) && $past(k5, 4); endproperty
   a_lock: assert property (p_lock) else $error("release without lock");
   property p_ilas_start; $rose(sy) |-> ##[1:140] k0; endproperty
   a_ilas_start: assert property (p_ilas_start) else $error("no ilas start");
   property p_ilas_close; k0 |-> ##[1:130] (k3 || !sy); endproperty
   a_ilas_close: assert property (p_ilas_close) else $error("no closing char");
   property p_sync_hold; $rose(sy) |=> sy [*4]; endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync glitch");
   c_sref: cover property (sysref);
   c_ilas: cover property (k0 ##[1:130] k3);
   c_drop: cover property ($fell(sy));
endmodule

// ### verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import jlt_pkg::*;
   `include "jlt_consts.svh"
   logic        ref_clk = 1'h0;
   logic        rst = 1'h1;
   jlt_cfg_t    cfg = '0;
   logic [13:0] samp_a = '0, samp_b = '0;
   logic        ovr_range = 1'h0, und_range = 1'h0, samp_valid = 1'h1, link_up;
   logic [7:0]  fchk0;
   logic [3:0]  avs_address = '0, avs_byteenable = 4'hF;
   logic        avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
   logic [31:0] avs_writedata = '0, avs_readdata, q;
   int          n_mismatch = 0, total_checks = 0;
   jlt_link_if  link ();
   jlt_tx jlt_tx_i (.ref_clk, .rst, .cfg, .samp_a, .samp_b, .ovr_range, .und_range,
      .samp_valid, .samp_take(), .samp_realign(), .fchk0(fchk0), .fchk1(), .link_up,
      .link(link.tx));
   jlt_rx jlt_rx_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .link(link.rx));
   jlt_link_sva jlt_link_sva_i (.ref_clk, .rst,
      .serial_lane0_output(link.serial_lane0_output),
      .serial_lane1_output(link.serial_lane1_output),
      .sync_request_input_pair(link.sync_request_input_pair), .sysref(link.sysref));
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // octet phase at read time is free, so any rotation of the frame is fine
   task automatic cmp4(input logic [31:0] got, input logic [31:0] exp);
      for (int r = 0; r < 3 && got !== exp; r++)
         exp = {exp[23:0], exp[31:24]};
      chk(got, exp);
   endtask
   // waitrequest is read before this edge's updates land, as the master sees it
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (n == 20) begin
         n_mismatch++;
         test_done();
      end
      @(posedge ref_clk);
   endtask
   task automatic wait_lu(input logic v);
      int n;
      for (n = 0; n < 4000 && link_up !== v; n++)
         @(posedge ref_clk);
      if (n == 4000) begin
         n_mismatch++;
         test_done();
      end
   endtask
   ////////////////////////////////////////
   initial begin
      jlt_cfg_t    c;
      logic [13:0] x, y;
      logic [15:0] wx, wy;
      logic [1:0]  t;
      logic [31:0] ctl;
      void'($urandom(87));
      repeat (5) @(posedge ref_clk);
      rst <= 1'h0;
      @(posedge ref_clk);
      // lanes, swap and subclass walk through all eight mixes; scrambling is lanes xor subclass
      for (int i = 0; i < 8; i++) begin
         bus(1'h1, `JLT_REG_CTRL, 32'h0);
         wait_lu(1'h0);
         x = 14'($urandom);
         y = 14'($urandom);
         c = '0;
         c.two_conv = (i != 4);
         c.two_lane = i[0];
         c.swap = i[1];
         c.subclass1 = i[2];
         c.scr_en = i[0] ^ i[2];
         c.cs_num = 2'h2;
         c.tail_sel = i[0] ? TAIL_CTRL : TAIL_ZERO;
         c.k_m1 = 5'(31 - ($urandom % (4 - i[0])) * 8);
         c.did = 8'($urandom);
         t = i[0] ? {1'($urandom), 1'h1} : 2'h0;
         cfg <= c;
         samp_a <= x;
         samp_b <= y;
         ovr_range <= t[1];
         wx = {i[1] ? y : x, t};
         wy = (i == 4) ? 16'h0 : {i[1] ? x : y, t};
         ctl = {23'h0, c.k_m1, c.two_lane, c.scr_en, c.subclass1, 1'h1};
         bus(1'h1, `JLT_REG_CTRL, ctl);
         bus(1'h0, `JLT_REG_CTRL, 32'h0);
         chk(q, ctl);
         wait_lu(1'h1);
         repeat (40) @(posedge ref_clk);
         bus(1'h0, `JLT_REG_STAT, 32'h0);
         chk(q & 32'h37, 32'h36);
         chk(fchk0, 8'(c.did + c.scr_en + c.k_m1 + c.two_conv + c.subclass1 + 31
                       + (c.two_lane ? 2 : 3)));
         bus(1'h0, `JLT_REG_DATA0, 32'h0);
         cmp4(q, c.two_lane ? {wx, wx} : {wx, wy});
         if (c.two_lane) begin
            bus(1'h0, `JLT_REG_DATA1, 32'h0);
            cmp4(q, {wy, wy});
         end
         $display("test %0d done", i);
      end
      bus(1'h0, 4'h2, 32'h0);
      chk(q, 32'h0);
      test_done();
   end
endmodule
